// ### hdl/actc_pkg.sv
// Package holding register map, field layouts, reset values and types of the core control block.
package actc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CORE_CONTROL_HIGH = 6'h00;
  localparam logic [5:0] ADDR_TRIG_LEVEL_LOW = 6'h04;
  localparam logic [5:0] ADDR_TRIG_LEVEL_HIGH = 6'h08;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h0C;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h10;
  localparam logic [5:0] ADDR_CORE_STATUS = 6'h14;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int NUM_INPUTS = 22;
  localparam int TRIG_LOW_BITS = 16;
  localparam int TRIG_HIGH_BITS = 6;
  localparam int LEAD_LSB = 10;
  localparam int RES_LSB = 8;
  localparam int DIV_LSB = 0;
  localparam int CHAN_LSB = 8;
  localparam int NUM_EVENTS = 3;
  localparam logic [15:0] CORE_CONTROL_WMASK = 16'h1F7F;
  localparam logic [15:0] TRIG_HIGH_WMASK = 16'h003F;
  localparam logic [15:0] CORE_CONTROL_RESET = 16'h0300;
  localparam logic [15:0] TRIG_LEVEL_RESET = 16'h0000;

  // Event bit positions in the status and mask registers.
  localparam int EV_EARLY = 0;
  localparam int EV_DONE = 1;
  localparam int EV_OVERRUN = 2;

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_6BIT = 2'h0;
  localparam logic [1:0] RES_8BIT = 2'h1;
  localparam logic [1:0] RES_10BIT = 2'h2;
  localparam logic [1:0] RES_12BIT = 2'h3;
  localparam logic [4:0] BITS_6 = 5'h06;
  localparam logic [4:0] BITS_8 = 5'h08;
  localparam logic [4:0] BITS_10 = 5'h0A;
  localparam logic [4:0] BITS_12 = 5'h0C;
  // Sample phase plus settling, in core clocks, added to the bit count.
  localparam logic [4:0] CONV_EXTRA_CLKS = 5'h02;
  // Lead code 0 means one core clock ahead.
  localparam logic [2:0] LEAD_OFFSET = 3'h1;
  localparam logic [7:0] DIV_MIN = 8'h02;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] early_irq_lead_sel;
    logic [1:0] resolution;
    logic [6:0] core_clk_divider;
  } actc_core_ctrl_t;

  typedef struct packed {
    logic busy;
    logic [4:0] channel;
  } actc_conv_state_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONVERT
  } actc_state_t;

endpackage

// ### hdl/actc_core_clk_div.sv
// Core clock enable divider: one pulse per core clock period.
`timescale 1ns/1ps

module actc_core_clk_div
  import actc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [6:0] div_code, // core clock divider code
  output logic core_clk_en // one-cycle pulse per core clock
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_en;
  logic [7:0] period;

  always_comb begin
    period = {div_code, 1'b0};
    if (period < DIV_MIN) begin
      period = DIV_MIN;
    end
    next_en = 1'b0;
    next_cnt = cnt - 8'h01;
    if (cnt == 8'h00) begin
      next_en = 1'b1;
      next_cnt = period - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= 8'h00;
      core_clk_en <= 1'b0;
    end else begin
      cnt <= next_cnt;
      core_clk_en <= next_en;
    end
  end

endmodule // actc_core_clk_div

// ### hdl/actc_top.sv
// Control for one conversion core: timing fields, trigger modes, sequencer and register slave.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

module actc_top
  import actc_pkg::*;
(
  input wire logic clk, // 200 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [5:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [31:0] avs_writedata, // Avalon write data
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic [NUM_INPUTS-1:0] trig_in, // asynchronous trigger pins
  output logic sar_start, // pulse: start one conversion
  output logic [4:0] sar_channel, // input being converted
  output logic [1:0] sar_resolution, // resolution of the conversion
  output logic core_clk_en, // core clock enable pulse
  output logic early_flag, // pulse: data ready in N core clocks
  output logic data_ready, // pulse: conversion result ready
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  actc_core_ctrl_t core_ctrl, next_core_ctrl;
  logic [NUM_INPUTS-1:0] trig_level, next_trig_level;
  logic [NUM_EVENTS-1:0] irq_status, next_irq_status;
  logic [NUM_EVENTS-1:0] irq_mask, next_irq_mask;
  logic [NUM_EVENTS-1:0] status_clr, next_status_clr;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_irq;
  logic [NUM_EVENTS-1:0] events;

  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0] be,
                                             input logic [15:0] wmask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & wmask;
    lane_merge = (old_val & ~m) | (wdata[15:0] & m);
  endfunction

  logic acc_commit;
  logic [15:0] core_ctrl_word;
  logic [15:0] core_ctrl_new;
  logic [15:0] trig_low_new;
  logic [15:0] trig_high_new;
  actc_conv_state_t conv_state;

  // The access completes on the edge where waitrequest is seen low.
  assign acc_commit = (avs_read | avs_write) & ~avs_waitrequest;
  assign core_ctrl_word = {3'h0, core_ctrl.early_irq_lead_sel, core_ctrl.resolution,
                           1'b0, core_ctrl.core_clk_divider};
  assign core_ctrl_new = lane_merge(core_ctrl_word, avs_writedata, avs_byteenable,
                                    CORE_CONTROL_WMASK);
  assign trig_low_new = lane_merge(trig_level[TRIG_LOW_BITS-1:0], avs_writedata,
                                   avs_byteenable, 16'hFFFF);
  assign trig_high_new = lane_merge({10'h000, trig_level[NUM_INPUTS-1:TRIG_LOW_BITS]},
                                    avs_writedata, avs_byteenable, TRIG_HIGH_WMASK);

  always_comb begin
    next_core_ctrl = core_ctrl;
    next_trig_level = trig_level;
    next_irq_mask = irq_mask;
    next_readdata = avs_readdata;
    next_status_clr = status_clr;
    next_waitrequest = 1'b1;
    if ((avs_read | avs_write) & avs_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000;
      next_status_clr = '0;
      if (avs_read) begin
        unique case (avs_address)
          ADDR_CORE_CONTROL_HIGH: next_readdata = {16'h0000, core_ctrl_word};
          ADDR_TRIG_LEVEL_LOW: next_readdata = {16'h0000, trig_level[TRIG_LOW_BITS-1:0]};
          ADDR_TRIG_LEVEL_HIGH: begin
            next_readdata = {26'h0000000, trig_level[NUM_INPUTS-1:TRIG_LOW_BITS]};
          end
          ADDR_IRQ_STATUS: begin
            next_readdata = {29'h00000000, irq_status};
            next_status_clr = irq_status;
          end
          ADDR_IRQ_MASK: next_readdata = {29'h00000000, irq_mask};
          ADDR_CORE_STATUS: begin
            next_readdata = {19'h00000, conv_state.channel, 7'h00, conv_state.busy};
          end
          default: next_readdata = 32'h0000_0000;
        endcase
      end
    end
    if (acc_commit & avs_write) begin
      unique case (avs_address)
        ADDR_CORE_CONTROL_HIGH: begin
          next_core_ctrl.early_irq_lead_sel = core_ctrl_new[LEAD_LSB+2:LEAD_LSB];
          next_core_ctrl.resolution = core_ctrl_new[RES_LSB+1:RES_LSB];
          next_core_ctrl.core_clk_divider = core_ctrl_new[DIV_LSB+6:DIV_LSB];
        end
        ADDR_TRIG_LEVEL_LOW: next_trig_level[TRIG_LOW_BITS-1:0] = trig_low_new;
        ADDR_TRIG_LEVEL_HIGH: begin
          next_trig_level[NUM_INPUTS-1:TRIG_LOW_BITS] = trig_high_new[TRIG_HIGH_BITS-1:0];
        end
        ADDR_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            next_irq_mask = avs_writedata[NUM_EVENTS-1:0];
          end
        end
        default: next_irq_mask = irq_mask;
      endcase
    end
    // Only bits that the read returned are cleared; a new event still wins.
    next_irq_status = irq_status;
    if (acc_commit & avs_read & (avs_address == ADDR_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~status_clr;
    end
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      core_ctrl <= actc_core_ctrl_t'({CORE_CONTROL_RESET[LEAD_LSB+2:LEAD_LSB],
                                      CORE_CONTROL_RESET[RES_LSB+1:RES_LSB],
                                      CORE_CONTROL_RESET[DIV_LSB+6:DIV_LSB]});
      trig_level <= {TRIG_LEVEL_RESET[TRIG_HIGH_BITS-1:0], TRIG_LEVEL_RESET};
      irq_status <= '0;
      irq_mask <= '0;
      status_clr <= '0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
    end else begin
      core_ctrl <= next_core_ctrl;
      trig_level <= next_trig_level;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      status_clr <= next_status_clr;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Trigger synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [NUM_INPUTS-1:0] sync1, sync2, sync3, trig_filt, trig_prev;
  logic [NUM_INPUTS-1:0] next_trig_filt, trig_rise;

  always_comb begin
    // A change is accepted only once the second and third stages agree.
    next_trig_filt = (sync2 & sync3) | (trig_filt & (sync2 ^ sync3));
    trig_rise = trig_filt & ~trig_prev;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      trig_filt <= '0;
      trig_prev <= '0;
    end else begin
      sync1 <= trig_in;
      sync2 <= sync1;
      sync3 <= sync2;
      trig_filt <= next_trig_filt;
      trig_prev <= trig_filt;
    end
  end

  // ----------------------------------------------------------------
  // Core clock divider
  // ----------------------------------------------------------------
  actc_core_clk_div u_div (
    .clk(clk),
    .resetn(resetn),
    .div_code(core_ctrl.core_clk_divider),
    .core_clk_en(core_clk_en)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  function automatic logic [4:0] first_set(input logic [NUM_INPUTS-1:0] v);
    first_set = 5'h00;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  function automatic logic [4:0] conv_clks(input logic [1:0] res);
    logic [4:0] bits;
    bits = BITS_12;
    unique case (res)
      RES_6BIT: bits = BITS_6;
      RES_8BIT: bits = BITS_8;
      RES_10BIT: bits = BITS_10;
      RES_12BIT: bits = BITS_12;
    endcase
    conv_clks = bits + CONV_EXTRA_CLKS;
  endfunction

  actc_state_t state, next_state;
  logic [NUM_INPUTS-1:0] edge_pend, next_edge_pend, want, start_mask;
  logic [4:0] remain, next_remain, next_channel;
  logic [1:0] next_resolution;
  logic next_start, next_early, next_ready;
  logic [2:0] lead_clks;

  always_comb begin
    next_state = state;
    next_remain = remain;
    next_channel = sar_channel;
    next_resolution = sar_resolution;
    next_start = 1'b0;
    next_early = 1'b0;
    next_ready = 1'b0;
    start_mask = '0;
    lead_clks = core_ctrl.early_irq_lead_sel + LEAD_OFFSET;
    // mode selects level or latched edge
    want = (trig_level & trig_filt) | (~trig_level & edge_pend);
    unique case (state)
      ST_IDLE: begin
        if (|want) begin
          next_channel = first_set(want);
          next_resolution = core_ctrl.resolution;
          next_remain = conv_clks(core_ctrl.resolution);
          next_start = 1'b1;
          start_mask[first_set(want)] = 1'b1;
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (core_clk_en) begin
          next_remain = remain - 5'h01;
          if (next_remain == {2'h0, lead_clks}) begin
            next_early = 1'b1;
          end
          if (next_remain == 5'h00) begin
            next_ready = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
    endcase
    // one start per edge; new edge wins over the clear
    next_edge_pend = (edge_pend & ~start_mask) | (trig_rise & ~trig_level);
    events = '0;
    events[EV_EARLY] = next_early;
    events[EV_DONE] = next_ready;
    events[EV_OVERRUN] = |(trig_rise & ~trig_level & edge_pend & ~start_mask);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      edge_pend <= '0;
      remain <= 5'h00;
      sar_channel <= 5'h00;
      sar_resolution <= CORE_CONTROL_RESET[RES_LSB+1:RES_LSB];
      sar_start <= 1'b0;
      early_flag <= 1'b0;
      data_ready <= 1'b0;
    end else begin
      state <= next_state;
      edge_pend <= next_edge_pend;
      remain <= next_remain;
      sar_channel <= next_channel;
      sar_resolution <= next_resolution;
      sar_start <= next_start;
      early_flag <= next_early;
      data_ready <= next_ready;
    end
  end

  assign conv_state.busy = (state == ST_CONVERT);
  assign conv_state.channel = sar_channel;

endmodule // actc_top

// ### tb/actc_top_checker.sv
// Port-level assertions of the core control block, bound to its top module.
`timescale 1ns/1ps

module actc_top_checker
  import actc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic resetn, // reset, low active
  input wire logic [5:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // wait
  input wire logic sar_start, // start pulse
  input wire logic [1:0] sar_resolution, // resolution
  input wire logic core_clk_en, // core clock
  input wire logic early_flag, // early pulse
  input wire logic data_ready, // done pulse
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [2:0] lead_m;
  logic [1:0] res_m;
  logic [6:0] div_m;
  logic [3:0] lead_cnt;
  logic [8:0] per_cnt;
  logic [1:0] per_ok;
  logic seen_early;
  logic wr_cc;
  logic [3:0] lead_now;
  logic [3:0] lead_exp;
  logic [8:0] per_exp;
  assign wr_cc = avs_write && !avs_waitrequest && avs_address == ADDR_CORE_CONTROL_HIGH;
  assign lead_now = lead_cnt + {3'h0, core_clk_en};
  assign lead_exp = {1'b0, lead_m} + 4'h1;
  assign per_exp = (div_m < 7'h02) ? 9'h002 : {1'b0, div_m, 1'b0};
  // Periods are judged from the third pulse after a divider write, since the first may be short.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lead_m <= 3'h0;
      res_m <= 2'h3;
      div_m <= 7'h00;
      lead_cnt <= 4'h0;
      per_cnt <= 9'h000;
      per_ok <= 2'h0;
      seen_early <= 1'b0;
    end else begin
      if (wr_cc && avs_byteenable[1]) begin
        lead_m <= avs_writedata[12:10];
        res_m <= avs_writedata[9:8];
      end
      if (wr_cc && avs_byteenable[0]) begin
        div_m <= avs_writedata[6:0];
      end
      lead_cnt <= early_flag ? 4'h0 : lead_now;
      per_cnt <= core_clk_en ? 9'h001 : per_cnt + 9'h001;
      if (wr_cc) begin
        per_ok <= 2'h0;
      end else if (core_clk_en && per_ok != 2'h2) begin
        per_ok <= per_ok + 2'h1;
      end
      seen_early <= early_flag ? 1'b1 : (data_ready ? 1'b0 : seen_early);
    end
  end
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_ack)
    else $error("bus request not answered after one wait cycle");
  hi_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_TRIG_LEVEL_HIGH
    |-> avs_readdata[31:6] == 26'h0)
    else $error("unused mode bits read nonzero");
  early_lead_a: assert property (data_ready |-> lead_now == lead_exp)
    else $error("early flag lead differs from lead code");
  early_first_a: assert property (data_ready |-> seen_early)
    else $error("data ready without early flag");
  div_period_a: assert property (core_clk_en && per_ok == 2'h2 |-> per_cnt == per_exp)
    else $error("core clock period differs from divider code");
  res_latch_a: assert property (sar_start |=> sar_resolution == $past(res_m))
    else $error("conversion resolution differs from code");
  start_pulse_a: assert property (sar_start |=> !sar_start)
    else $error("start pulse longer than one cycle");
  reset_vals_a: assert property ($rose(resetn) |-> avs_waitrequest && !irq && !sar_start)
    else $error("outputs not at reset values");
endmodule // actc_top_checker

bind actc_top actc_top_checker actc_top_checker_i (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sar_start(sar_start),
  .sar_resolution(sar_resolution), .core_clk_en(core_clk_en), .early_flag(early_flag),
  .data_ready(data_ready), .irq(irq));

// ### tb/actc_trig_src.sv
// Trigger source model driving the analog trigger pins.
`timescale 1ns/1ps

module actc_trig_src
  import actc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic [NUM_INPUTS-1:0] fire, // request one pulse
  input wire logic [NUM_INPUTS-1:0] hold, // held level
  output logic [NUM_INPUTS-1:0] trig_in // trigger pins
);
  logic [3:0] left [NUM_INPUTS] = '{default: 4'h0};
  // A pulse lasts 8 clocks so that all synchroniser stages see it.
  always @(posedge clk) begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      left[i] <= fire[i] ? 4'h8 : (left[i] != 4'h0 ? left[i] - 4'h1 : 4'h0);
    end
  end
  always_comb begin
    for (int j = 0; j < NUM_INPUTS; j++) begin
      trig_in[j] = hold[j] | (left[j] != 4'h0);
    end
  end
endmodule // actc_trig_src

// ### tb/actc_top_tb.sv
// Self-checking bench of the core control block.
`timescale 1ns/1ps

module actc_top_tb
  import actc_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sar_start, core_clk_en, early_flag, data_ready, irq;
  logic [4:0] sar_channel;
  logic [1:0] sar_resolution;
  logic [NUM_INPUTS-1:0] trig_in;
  logic [NUM_INPUTS-1:0] fire = '0;
  logic [NUM_INPUTS-1:0] hold = '0;
  logic [31:0] rd;
  int miscompares = 0;
  int compares = 0;
  int nstart = 0;
  int seed = 2;
  logic [5:0] addr_tab [4] = '{ADDR_CORE_CONTROL_HIGH, ADDR_TRIG_LEVEL_LOW,
    ADDR_TRIG_LEVEL_HIGH, 6'h3C};
  logic [15:0] rst_tab [4] = '{CORE_CONTROL_RESET, TRIG_LEVEL_RESET, TRIG_LEVEL_RESET, 16'h0000};

  always #2.5 clk = ~clk;
  always @(posedge clk) if (sar_start === 1'b1) nstart <= nstart + 1;

  actc_top actc_top_i (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .trig_in(trig_in), .sar_start(sar_start), .sar_channel(sar_channel),
    .sar_resolution(sar_resolution), .core_clk_en(core_clk_en), .early_flag(early_flag),
    .data_ready(data_ready), .irq(irq));
  actc_trig_src actc_trig_src_i (.clk(clk), .fire(fire), .hold(hold), .trig_in(trig_in));

  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then takes read data.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      chk("bus wait", 32'h0, 32'h1);
      close_out();
    end
  endtask

  function automatic logic [15:0] wmask(input logic [5:0] a);
    case (a)
      ADDR_CORE_CONTROL_HIGH: return CORE_CONTROL_WMASK;
      ADDR_TRIG_LEVEL_LOW: return 16'hFFFF;
      ADDR_TRIG_LEVEL_HIGH: return TRIG_HIGH_WMASK;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic fire_wait(input int ch);
    int n;
    n = 0;
    @(posedge clk);
    fire[ch] <= 1'b1;
    @(posedge clk);
    fire[ch] <= 1'b0;
    while (data_ready !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (data_ready !== 1'b1) begin
      chk("conversion wait", 32'h0, 32'h1);
      close_out();
    end
  endtask

  task automatic edge_conv(input int ch, input logic [2:0] lead, input logic [1:0] res);
    int n0;
    bus(1'b1, ADDR_CORE_CONTROL_HIGH, {3'h0, lead, res, 8'h01});
    n0 = nstart;
    fire_wait(ch);
    chk("channel", ch, {27'h0, sar_channel});
    chk("resolution", {30'h0, res}, {30'h0, sar_resolution});
    repeat (40) @(posedge clk);
    chk("edge starts", n0 + 1, nstart);
  endtask

  task automatic wait_en(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core_clk_en !== 1'b1 && n < 600);
    if (core_clk_en !== 1'b1) begin
      chk("core clock wait", 32'h0, 32'h1);
      close_out();
    end
  endtask

  initial begin
    int ch;
    int n0;
    logic [15:0] v;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, addr_tab[i], 16'h0000);
      chk("reset value", {16'h0, rst_tab[i]}, rd);
    end
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      v = 16'($random(seed));
      bus(1'b1, addr_tab[i % 4], v);
      bus(1'b0, addr_tab[i % 4], 16'h0000);
      chk("readback", {16'h0, v & wmask(addr_tab[i % 4])}, rd);
    end
    bus(1'b1, ADDR_TRIG_LEVEL_LOW, 16'h0000);
    bus(1'b1, ADDR_TRIG_LEVEL_HIGH, 16'h0000);
    // Only the low lane is enabled, so the lead and resolution fields must keep their zeros.
    bus(1'b1, ADDR_CORE_CONTROL_HIGH, 16'h0000);
    avs_byteenable <= 4'h1;
    bus(1'b1, ADDR_CORE_CONTROL_HIGH, 16'hFFFF);
    avs_byteenable <= 4'hF;
    bus(1'b0, ADDR_CORE_CONTROL_HIGH, 16'h0000);
    chk("lane write", {16'h0, CORE_CONTROL_WMASK & 16'h00FF}, rd);
    $display("test register access done");
    for (int i = 0; i < 5; i++) begin
      ch = $unsigned($random(seed)) % NUM_INPUTS;
      edge_conv(ch, 3'(i), 2'(i % 3));
    end
    edge_conv(NUM_INPUTS - 1, 3'h4, 2'h0);
    $display("test edge conversions done");
    ch = 16 + $unsigned($random(seed)) % 6;
    bus(1'b1, ADDR_TRIG_LEVEL_HIGH, 16'h0001 << (ch - 16));
    n0 = nstart;
    hold[ch] <= 1'b1;
    repeat (200) @(posedge clk);
    hold[ch] <= 1'b0;
    repeat (60) @(posedge clk);
    chk("level restarts", 32'h1, {31'h0, nstart - n0 >= 3});
    bus(1'b1, ADDR_TRIG_LEVEL_HIGH, 16'h0000);
    n0 = nstart;
    hold[ch] <= 1'b1;
    repeat (200) @(posedge clk);
    hold[ch] <= 1'b0;
    chk("edge held", n0 + 1, nstart);
    $display("test trigger modes done");
    bus(1'b0, ADDR_IRQ_STATUS, 16'h0000);
    bus(1'b1, ADDR_IRQ_MASK, 16'h0001);
    fire_wait(3);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    bus(1'b0, ADDR_IRQ_STATUS, 16'h0000);
    chk("status", 32'h3, rd);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, ADDR_IRQ_MASK, 16'h0000);
    fire_wait(0);
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b0, ADDR_IRQ_STATUS, 16'h0000);
    chk("masked status", 32'h3, rd);
    $display("test interrupt done");
    bus(1'b1, ADDR_CORE_CONTROL_HIGH, 16'h037F);
    wait_en(n0);
    wait_en(n0);
    wait_en(n0);
    chk("core clock period", 32'd254, n0);
    $display("test divider done");
    // Two inputs rise together; the second edge on input 1 while it still waits is an overrun.
    @(posedge clk);
    fire[1:0] <= 2'h3;
    @(posedge clk);
    fire[1:0] <= 2'h0;
    repeat (20) @(posedge clk);
    fire_wait(1);
    bus(1'b0, ADDR_IRQ_STATUS, 16'h0000);
    chk("overrun status", 32'h7, rd);
    bus(1'b0, ADDR_CORE_STATUS, 16'h0000);
    chk("core status", 32'h0000_0101, rd);
    $display("test overrun done");
    close_out();
  end
endmodule // actc_top_tb
